/* fcs_pkg.sv */
// Overview of operation
// - Write 90h before reading identification codes.
// - Identification persists until another valid command.
// - Host zeroes every byte before erase; the sequencer only refuses erase while array_zeroed is low.
// - Write 20h twice to launch erase.
// - A0h write carries verify address, latched.
// - Per byte: A0h write then one read.
// - Wait 6 us after strobe before read.
// - Write: strobe low under select; address, data latched.
// - Failed verify: erase again, resume at address; the sequencer only reports verify_ok low.
`default_nettype none
package fcs_pkg;
  // Bus geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  // Command bytes
  localparam logic [7:0] CMD_READ    = 8'h00;
  localparam logic [7:0] CMD_IDENT   = 8'h90;
  localparam logic [7:0] CMD_ERASE   = 8'h20;
  localparam logic [7:0] CMD_EVERIFY = 8'ha0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Identification addresses
  localparam logic [16:0] ID_ADDR_MAKER = 17'h00000;
  localparam logic [16:0] ID_ADDR_TYPE  = 17'h00001;
  // Timing, clock period and least times in ns
  localparam int unsigned CLK_NS     = 100;
  localparam int unsigned T_WRR_NS   = 6000;
  localparam int unsigned T_ERASE_NS = 9500000;
  localparam int unsigned WRR_CYC    = (T_WRR_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ERASE_CYC_DEF =
    (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
  // Pin cycle step counts
  localparam logic [2:0] RD_SAMPLE_STEP = 3'h3;
  localparam logic [2:0] WR_LAST_STEP   = 3'h2;
  // Host operations
  typedef enum logic [1:0] {
    OP_READ, OP_IDENT, OP_ERASE, OP_EVERIFY
  } fcs_op_e;
  // Device mode as tracked by the host
  typedef enum logic [2:0] {
    MODE_READ, MODE_IDENT, MODE_ERASE_ARMED, MODE_ERASING, MODE_EVERIFY
  } fcs_mode_e;
  localparam fcs_mode_e MODE_RESET = MODE_READ;
endpackage
`default_nettype wire

/* fcs_bus_if.sv */
`timescale 1ns/100ps
`default_nettype none
// One pin cycle request between sequencer and pin engine
interface fcs_bus_if #(parameter int AW = 17, parameter int DW = 8);
  logic          req;    // One-cycle start pulse
  logic          wr;     // High for a command write
  logic [AW-1:0] addr;   // Cycle address
  logic [DW-1:0] wdata;  // Command byte
  logic          done;   // One-cycle completion pulse
  logic [DW-1:0] rdata;  // Sampled read byte
  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

/* fcs_bus_engine.sv */
`timescale 1ns/100ps
`default_nettype none
module fcs_bus_engine
  import fcs_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Sequencer side
  fcs_bus_if.eng             bus,
  // Flash pins
  output logic               flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      flash_dq_out,
  output logic               flash_dq_oe_n,
  input  wire logic [DW-1:0] flash_dq_in
);
  typedef enum logic [1:0] {E_IDLE, E_WRITE, E_READ} fcs_eng_e;
  fcs_eng_e      st_r;    // Engine state
  logic [2:0]    step_r;  // Step inside a cycle
  logic [DW-1:0] dq_s1_r; // First sync stage
  logic [DW-1:0] dq_s2_r; // Second sync stage

  // Data pins are asynchronous to us, two flops before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // Pin sequencing, one clock per step keeps every width >= 100 ns
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r          <= E_IDLE;
      step_r        <= '0;
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_addr    <= '0;
      flash_dq_out  <= '0;
      flash_dq_oe_n <= 1'b1;
      bus.done      <= 1'b0;
      bus.rdata     <= '0;
    end else begin
      bus.done <= 1'b0;
      case (st_r)
        E_IDLE: begin
          // Address set with select, before the strobe falls
          if (bus.req) begin
            st_r       <= bus.wr ? E_WRITE : E_READ;
            step_r     <= '0;
            flash_ce_n <= 1'b0;
            flash_addr <= bus.addr;
            if (bus.wr) begin
              flash_dq_out  <= bus.wdata;
              flash_dq_oe_n <= 1'b0;
            end
          end
        end
        E_WRITE: begin
          step_r <= step_r + 3'h1;
          if (step_r == '0) begin
            flash_we_n <= 1'b0;
          end else if (step_r == 3'h1) begin
            flash_we_n <= 1'b1;
          end else if (step_r == WR_LAST_STEP) begin
            // Data held one cycle past the rising strobe
            flash_ce_n    <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            bus.done      <= 1'b1;
            st_r          <= E_IDLE;
          end
        end
        E_READ: begin
          step_r <= step_r + 3'h1;
          if (step_r == '0) begin
            flash_oe_n <= 1'b0;
          end else if (step_r == RD_SAMPLE_STEP) begin
            // Sync delay covers output valid time with margin
            bus.rdata  <= dq_s2_r;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            bus.done   <= 1'b1;
            st_r       <= E_IDLE;
          end
        end
        default: st_r <= E_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* fcs_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module fcs_ctrl
  import fcs_pkg::*;
#(
  parameter int unsigned ERASE_CYC = ERASE_CYC_DEF,
  parameter int          AW        = ADDR_W,
  parameter int          DW        = DATA_W
) (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // Command port
  input  wire logic          cmd_valid,
  input  wire fcs_op_e       cmd_op,
  input  wire logic [AW-1:0] cmd_addr,
  input  wire logic          array_zeroed,
  output logic               cmd_ready,
  // Answer port
  output logic               resp_valid,
  output logic [DW-1:0]      resp_data,
  output logic               resp_err,
  output logic               verify_ok,
  // Flash pins
  output logic               flash_ce_n,
  output logic               flash_oe_n,
  output logic               flash_we_n,
  output logic [AW-1:0]      flash_addr,
  output logic [DW-1:0]      flash_dq_out,
  output logic               flash_dq_oe_n,
  input  wire logic [DW-1:0] flash_dq_in
);
  localparam int EW = $clog2(ERASE_CYC + 1);
  localparam logic [7:0] WRR_CYC8 = 8'(WRR_CYC);
  localparam logic [EW-1:0] ERASE_LAST = EW'(ERASE_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_WRITE, ST_RECOV, ST_READ, ST_ERASE
  } fcs_state_e;

  fcs_state_e    st_r;         // Sequencer state
  fcs_op_e       op_r;         // Operation in hand
  fcs_mode_e     mode_r;       // Device mode we believe in
  logic [AW-1:0] addr_r;       // Operation address
  logic [7:0]    byte_r;       // Command byte to write
  logic [1:0]    wr_left_r;    // Command writes still due
  logic          req_r;        // Start pulse to engine
  logic          ready_r;      // Idle and accepting
  logic [7:0]    since_wr_r;   // Cycles since strobe went high
  logic [EW-1:0] ecnt_r;       // Erase time counter
  logic          resp_valid_r; // Answer strobe
  logic [DW-1:0] resp_data_r;  // Answer byte
  logic          resp_err_r;   // Request refused
  logic          verify_ok_r;  // Verified byte read FFh

  fcs_bus_if #(.AW(AW), .DW(DW)) bus ();

  // Pin engine does the actual bus cycles
  fcs_bus_engine #(.AW(AW), .DW(DW)) u_eng (
    .clock         (clock),
    .rst           (rst),
    .bus           (bus),
    .flash_ce_n    (flash_ce_n),
    .flash_oe_n    (flash_oe_n),
    .flash_we_n    (flash_we_n),
    .flash_addr    (flash_addr),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_dq_in   (flash_dq_in)
  );

  // Request fields; identification reads pick the code by bit 0
  assign bus.req   = req_r;
  assign bus.wr    = (st_r == ST_WRITE);
  assign bus.wdata = byte_r;
  assign bus.addr  = (op_r == OP_IDENT && st_r != ST_WRITE) ?
                     (addr_r[0] ? AW'(ID_ADDR_TYPE)
                                : AW'(ID_ADDR_MAKER)) :
                     addr_r;

  // Answer outputs straight from flops
  assign cmd_ready  = ready_r;
  assign resp_valid = resp_valid_r;
  assign resp_data  = resp_data_r;
  assign resp_err   = resp_err_r;
  assign verify_ok  = verify_ok_r;

  // Main sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r      <= ST_IDLE;
      op_r      <= OP_READ;
      addr_r    <= '0;
      byte_r    <= CMD_READ;
      wr_left_r <= '0;
      req_r     <= 1'b0;
      ready_r   <= 1'b1;
    end else begin
      req_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (cmd_valid) begin
            op_r      <= cmd_op;
            addr_r    <= cmd_addr;
            wr_left_r <= 2'h1;
            ready_r   <= 1'b0;
            case (cmd_op)
              OP_READ: begin
                // Skip the command while already reading the array
                byte_r <= CMD_READ;
                req_r  <= (mode_r != MODE_READ);
                st_r   <= (mode_r != MODE_READ) ? ST_WRITE : ST_RECOV;
              end
              OP_IDENT: begin
                // Command entry, no high voltage on address_line_nine
                byte_r <= CMD_IDENT;
                req_r  <= (mode_r != MODE_IDENT);
                st_r   <= (mode_r != MODE_IDENT) ? ST_WRITE : ST_RECOV;
              end
              OP_ERASE: begin
                if (array_zeroed) begin
                  byte_r    <= CMD_ERASE;
                  wr_left_r <= 2'h2;
                  req_r     <= 1'b1;
                  st_r      <= ST_WRITE;
                end else begin
                  ready_r <= 1'b1;
                end
              end
              OP_EVERIFY: begin
                byte_r <= CMD_EVERIFY;
                req_r  <= 1'b1;
                st_r   <= ST_WRITE;
              end
              default: ready_r <= 1'b1;
            endcase
          end
        end
        ST_WRITE: begin
          if (bus.done) begin
            if (wr_left_r > 2'h1) begin
              // Same write repeated launches the erase
              wr_left_r <= wr_left_r - 2'h1;
              req_r     <= 1'b1;
            end else if (op_r == OP_ERASE) begin
              st_r <= ST_ERASE;
            end else begin
              st_r <= ST_RECOV;
            end
          end
        end
        ST_RECOV: begin
          // Output gate held off until recovery has passed
          if (since_wr_r >= WRR_CYC8) begin
            req_r <= 1'b1;
            st_r  <= ST_READ;
          end
        end
        ST_READ: begin
          if (bus.done) begin
            st_r    <= ST_IDLE;
            ready_r <= 1'b1;
          end
        end
        ST_ERASE: begin
          // Least erase time; a later verify write ends it
          if (ecnt_r == ERASE_LAST) begin
            st_r    <= ST_IDLE;
            ready_r <= 1'b1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Mode tracking, advanced only by completed command writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_RESET;
    end else if (st_r == ST_WRITE && bus.done) begin
      case (byte_r)
        CMD_READ:    mode_r <= MODE_READ;
        CMD_IDENT:   mode_r <= MODE_IDENT;
        CMD_ERASE:   mode_r <= (mode_r == MODE_ERASE_ARMED) ?
                               MODE_ERASING : MODE_ERASE_ARMED;
        CMD_EVERIFY: mode_r <= MODE_EVERIFY;
        default:     mode_r <= mode_r;
      endcase
    end
  end

  // Recovery counter, restarted while the strobe is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      since_wr_r <= 8'hff;
    end else if (!flash_we_n) begin
      since_wr_r <= '0;
    end else if (since_wr_r != 8'hff) begin
      since_wr_r <= since_wr_r + 8'h01;
    end
  end

  // Erase timer; the device stop timer covers any overrun
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ecnt_r <= '0;
    end else if (st_r == ST_ERASE) begin
      ecnt_r <= ecnt_r + EW'(1);
    end else begin
      ecnt_r <= '0;
    end
  end

  // Answers: read data, erase completion, refusal
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resp_valid_r <= 1'b0;
      resp_data_r  <= '0;
      resp_err_r   <= 1'b0;
      verify_ok_r  <= 1'b0;
    end else begin
      resp_valid_r <= 1'b0;
      if (st_r == ST_READ && bus.done) begin
        resp_valid_r <= 1'b1;
        resp_data_r  <= bus.rdata;
        resp_err_r   <= 1'b0;
        // Failed byte: caller erases again and resumes here
        verify_ok_r  <= (op_r == OP_EVERIFY) &&
                        (bus.rdata == ERASED_BYTE);
      end else if (st_r == ST_ERASE && ecnt_r == ERASE_LAST) begin
        resp_valid_r <= 1'b1;
        resp_err_r   <= 1'b0;
        verify_ok_r  <= 1'b0;
      end else if (st_r == ST_IDLE && cmd_valid &&
                   cmd_op == OP_ERASE && !array_zeroed) begin
        resp_valid_r <= 1'b1;
        resp_err_r   <= 1'b1;
        verify_ok_r  <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_we_under_select: assert property (
    !flash_we_n |-> !flash_ce_n && !flash_dq_oe_n && flash_oe_n)
    else $error("write strobe low without select or data");
  a_we_pulse_one: assert property (
    $fell(flash_we_n) |=> $rose(flash_we_n) && !flash_dq_oe_n)
    else $error("write strobe pulse or data hold wrong");
  a_read_recovery: assert property (
    $fell(flash_oe_n) |-> since_wr_r >= WRR_CYC8)
    else $error("output gate low too soon after write");
  a_ident_first: assert property (
    (st_r == ST_READ && op_r == OP_IDENT) |-> mode_r == MODE_IDENT)
    else $error("identification read without 90h");
  a_array_mode: assert property (
    (st_r == ST_READ && op_r == OP_READ) |-> mode_r == MODE_READ)
    else $error("array read outside read mode");
  a_erase_twice: assert property (
    (st_r == ST_WRITE && bus.done && op_r == OP_ERASE &&
     wr_left_r == 2'h1) |-> mode_r == MODE_ERASE_ARMED ##1
    (mode_r == MODE_ERASING && st_r == ST_ERASE))
    else $error("erase launched without arming write");
  a_verify_addr: assert property (
    ($fell(flash_we_n) && byte_r == CMD_EVERIFY) |->
    flash_addr == addr_r && flash_dq_out == CMD_EVERIFY)
    else $error("verify write lacks byte address");
  a_verify_read: assert property (
    (st_r == ST_WRITE && bus.done && op_r == OP_EVERIFY) |->
    ##[1:80] !flash_oe_n)
    else $error("verify write not followed by read");
  a_zeroed_gate: assert property (
    (st_r == ST_IDLE && cmd_valid && cmd_op == OP_ERASE &&
     !array_zeroed) |=> st_r == ST_IDLE && resp_err_r && flash_we_n)
    else $error("erase issued on unzeroed array");

  c_verify_pass: cover property (resp_valid_r && verify_ok_r);
  c_ident_read: cover property (st_r == ST_READ && op_r == OP_IDENT
                                && bus.done);
  c_erase_done: cover property (st_r == ST_ERASE && ecnt_r == ERASE_LAST);
  c_refused: cover property (resp_valid_r && resp_err_r);
endmodule
`default_nettype wire

/* fcs_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Behavioural byte-wide flash on the far side of the pins
module fcs_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5a,  // Arbitrary value
  parameter logic [7:0] TYPE_CODE  = 8'hc3,  // Arbitrary value
  parameter logic [7:0] FILL_BASE  = 8'h10,  // First stored byte
  parameter int         STOP_NS    = 50000   // Internal stop timer
) (
  // Control pins
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  // Address and data
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  dq_host,
  input  wire logic        dq_host_oe_n,
  output logic      [7:0]  dq_dev,
  // Observation counters
  output var int           write_cnt,
  output var int           erase_cnt,
  output var int           timing_viol
);
  logic [7:0]  mem [16];  // Small array, address wraps at 16
  logic [16:0] wr_addr;   // Address taken at strobe fall
  logic [16:0] vfy_addr;  // Byte chosen for the margin read
  logic [1:0]  mode;      // 0 array, 1 ident, 2 verify
  logic        armed;     // First erase write seen
  logic        erasing;   // Erase in progress
  logic [7:0]  last_q;    // Last byte driven
  realtime     t_wr;      // Time of last strobe rise

  // Byte offered in the current mode
  function automatic logic [7:0] rd_byte(input logic [16:0] a);
    if (mode == 2'd1) begin
      return (a == 17'h00000) ? MAKER_CODE :
             (a == 17'h00001) ? TYPE_CODE : 8'h00;
    end else if (mode == 2'd2) begin
      return mem[vfy_addr[3:0]];
    end
    return mem[a[3:0]];
  endfunction

  // Erase drives every byte to the erased value
  task automatic erase_fill();
    for (int i = 0; i < 16; i++) mem[i] = 8'hff;
    erasing = 1'b0;
  endtask

  // Power-up state: array read with a cleared command
  initial begin
    mode = 2'd0;
    armed = 1'b0;
    erasing = 1'b0;
    last_q = 8'h00;
    t_wr = -1.0e9;
    write_cnt = 0;
    erase_cnt = 0;
    timing_viol = 0;
    for (int i = 0; i < 16; i++) mem[i] = FILL_BASE + 8'(i);
  end

  // Address latched as the strobe falls under select
  always @(negedge we_n) begin
    if (!ce_n) begin
      wr_addr = addr;
    end
  end

  // Command decode on the strobe rise; data bus must be driven
  always @(posedge we_n) begin
    if (!ce_n && !dq_host_oe_n) begin
      t_wr = $realtime;
      write_cnt++;
      case (dq_host)
        8'h00: begin
          mode = 2'd0;
          armed = 1'b0;
        end
        8'h90: begin
          mode = 2'd1;
          armed = 1'b0;
        end
        8'h20: begin
          if (armed) begin
            erasing = 1'b1;
            erase_cnt++;
          end
          armed = !armed;
        end
        8'ha0: begin
          vfy_addr = wr_addr;
          mode = 2'd2;
          armed = 1'b0;
          if (erasing) erase_fill();
        end
        default: ;
      endcase
    end
  end

  // Stop timer halts an erase nobody ended, then idles
  always @(posedge erasing) begin
    #(STOP_NS);
    if (erasing) erase_fill();
  end

  // Read start: record the byte and check write recovery
  always @(negedge oe_n) begin
    if (!ce_n) begin
      last_q = rd_byte(addr);
      if ($realtime - t_wr < 6000.0) timing_viol++;
    end
  end

  // Released bus shows the inverse of the last byte, not a held one
  assign dq_dev = (!ce_n && !oe_n) ? rd_byte(addr) : ~last_q;
endmodule
`default_nettype wire

/* test_flash_command_read_erase.sv */
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the flash command sequencer
module test_flash_command_read_erase;
  import fcs_pkg::*;
  localparam int unsigned ERASE_N = 20;     // Short erase for sim
  localparam int          LIMIT   = 20000;  // Cycle ceiling
  localparam logic [7:0]  MAKER   = 8'h5a;  // Arbitrary value
  localparam logic [7:0]  DTYPE   = 8'hc3;  // Arbitrary value
  localparam logic [7:0]  BASE    = 8'h10;  // First stored byte
  logic        clock, rst, cmd_valid, array_zeroed;
  fcs_op_e     cmd_op;
  logic [16:0] cmd_addr, f_addr;
  logic        cmd_ready, resp_valid, resp_err, verify_ok;
  logic [7:0]  resp_data, dq_out, dq_in, got_d;
  logic        ce_n, oe_n, we_n, dq_oe_n, got_e, got_ok;
  int          error_cnt, compares, cycles, wr_cnt, er_cnt, t_viol, w0;

  fcs_ctrl #(.ERASE_CYC(ERASE_N)) dut_u (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .array_zeroed(array_zeroed),
    .cmd_ready(cmd_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_err(resp_err), .verify_ok(verify_ok),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_addr(f_addr), .flash_dq_out(dq_out),
    .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in));

  fcs_flash_model #(.MAKER_CODE(MAKER), .TYPE_CODE(DTYPE),
                    .FILL_BASE(BASE)) flash_u (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(f_addr),
    .dq_host(dq_out), .dq_host_oe_n(dq_oe_n), .dq_dev(dq_in),
    .write_cnt(wr_cnt), .erase_cnt(er_cnt), .timing_viol(t_viol));

  // Free-running clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Compare and count; unknowns never match
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // Closing report and verdict
  task automatic end_sim();
    $display("error_cnt=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One request, then a bounded wait for its answer pulse
  task automatic do_op(input fcs_op_e op, input logic [16:0] a);
    int n;
    n = 0;
    @(posedge clock);
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n >= 200) begin
      $display("[ERR] t=%0t ready timeout got=%h exp=%h", $time, 1'b0, 1'b1);
      error_cnt++;
    end
    cmd_op <= op;
    cmd_addr <= a;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    // A refused erase answers at the accepting edge itself
    #1;
    n = 0;
    while (resp_valid !== 1'b1 && n < 3000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 3000) begin
      $display("[ERR] t=%0t answer timeout got=%h exp=%h", $time, 1'b0, 1'b1);
      error_cnt++;
    end
    got_d = resp_data;
    got_e = resp_err;
    got_ok = verify_ok;
  endtask

  // Idle pin levels after reset
  task automatic t_reset();
    check({28'h0, ce_n, oe_n, we_n, dq_oe_n}, 32'hf);
    check({31'h0, cmd_ready}, 32'h1);
  endtask

  // Array reads straight from power-up, repeated
  task automatic t_array_read();
    do_op(OP_READ, 17'h00003);
    check({24'h0, got_d}, {24'h0, BASE + 8'h03});
    check(wr_cnt, 0);
    do_op(OP_READ, 17'h1000e);
    check({24'h0, got_d}, {24'h0, BASE + 8'h0e});
  endtask

  // Identification codes, then back to the array
  task automatic t_ident();
    do_op(OP_IDENT, ID_ADDR_MAKER);
    check({24'h0, got_d}, {24'h0, MAKER});
    do_op(OP_IDENT, ID_ADDR_TYPE);
    check({24'h0, got_d}, {24'h0, DTYPE});
    check(wr_cnt, 1);
    do_op(OP_READ, 17'h00007);
    check({24'h0, got_d}, {24'h0, BASE + 8'h07});
    check(wr_cnt, 2);
  endtask

  // Margin read of an unerased byte must report failure
  task automatic t_verify_fail();
    do_op(OP_EVERIFY, 17'h00002);
    check({31'h0, got_ok}, 32'h0);
    check({24'h0, got_d}, {24'h0, BASE + 8'h02});
  endtask

  // Erase refused when the array is not zeroed, then done
  task automatic t_erase();
    array_zeroed <= 1'b0;
    w0 = wr_cnt;
    do_op(OP_ERASE, 17'h00000);
    check({31'h0, got_e}, 32'h1);
    check(wr_cnt, w0);
    array_zeroed <= 1'b1;
    do_op(OP_ERASE, 17'h00000);
    check({31'h0, got_e}, 32'h0);
    check(er_cnt, 1);
    check(wr_cnt, w0 + 2);
    // Verify walk over several bytes
    for (int i = 0; i < 4; i++) begin
      do_op(OP_EVERIFY, 17'(i * 5));
      check({31'h0, got_ok}, 32'h1);
      check({24'h0, got_d}, {24'h0, ERASED_BYTE});
    end
    do_op(OP_READ, 17'h00009);
    check({24'h0, got_d}, {24'h0, ERASED_BYTE});
    check(t_viol, 0);
  endtask

  // Hang guard
  initial begin
    cycles = 0;
    forever begin
      @(posedge clock);
      cycles++;
      if (cycles >= LIMIT) begin
        error_cnt++;
        end_sim();
      end
    end
  end

  // Main sequence
  initial begin
    error_cnt = 0;
    compares = 0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = 17'h00000;
    array_zeroed = 1'b0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    t_reset();
    t_array_read();
    t_ident();
    t_verify_fail();
    t_erase();
    end_sim();
  end
endmodule
`default_nettype wire
